// ===== design/sis_top.sv
/*
  Status indicator sequencer: inverter lamps, four-key menu and display
  selection, battery unit lamp patterns, setting gate and charge window,
  with an Avalon-MM register slave and one level interrupt.
  Assumes every input is synchronous to sys_clk_i and keys are levels.
*/
// Added by the designer: the address map and the Avalon-MM interface to the registers.
// Behaviour
// - Operating lamp solid blue normal, blinking blue waiting, dark on fault.
// - Error lamp solid red on inverter fault, dark when normal.
// - Battery lamp solid green healthy link, blinking idle, off on fault.
// - Normal display cycles power, daily, battery pages; fault shows code.
// - Escape leaves, up and down move or adjust, enter confirms.
// - While idle, settings apply only if charge exceeds new minimum by 2%.
// - Charging starts once system time lies inside the new window.
// - Battery unit drives one status lamp and four charge lamps.
// - Hold button about 1 s to start; yellow flash each 0.1 s.
// - After self test, status flashes green every 0.5 s, charge lamps off.
// - Link success gives solid green status and capacity-based charge lamps.
// - Hold over 1 s running: blue chase, all dark 2.4 s after release.
// - Standby flashes green 1 s then dark 4 s, charge lamps off.
// - Charging or discharging keeps status green, charge lamps follow level.
// - Fault holds red ten minutes, then red 1 s, dark 4 s.
// - Warning repeats yellow 1 s then dark 4 s.
// - Discharging flashes lamps up to quarter level reached, at least first.
module sis_top #(
  parameter int unsigned TICK_CYCLES = sis_pkg::TICK_CYCLES_DEF
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o,
  input wire sis_pkg::sis_inv_t inv_state_i,
  input wire sis_pkg::sis_link_t inv_bat_link_i,
  input wire logic [15:0] inv_err_code_i,
  input wire sis_pkg::sis_keys_t keys_i,
  input wire logic battery_power_button_i,
  input wire logic bat_link_ok_i,
  input wire logic bat_charging_i,
  input wire logic bat_discharging_i,
  input wire logic bat_fault_i,
  input wire logic bat_warning_i,
  input wire logic [6:0] soc_i,
  output logic op_lamp_blue_o,
  output logic err_lamp_red_o,
  output logic bat_lamp_green_o,
  output sis_pkg::sis_disp_t disp_o,
  output logic charge_req_o,
  output sis_pkg::sis_rgb_t status_lamp_o,
  output sis_pkg::sis_lamp_t charge_level_lamp_first_o,
  output sis_pkg::sis_lamp_t charge_level_lamp_second_o,
  output sis_pkg::sis_lamp_t charge_level_lamp_third_o,
  output sis_pkg::sis_lamp_t charge_level_lamp_fourth_o
);
  import sis_pkg::*;

  localparam logic [24:0] TICK_LAST = 25'(TICK_CYCLES - 1);

  typedef struct packed {
    logic [24:0] tick_cnt;
    logic tick;
    logic [5:0] phase;
    logic [2:0] slow_cnt;
    logic slow_on;
    logic fast_on;
    sis_bat_t bst;
    logic [12:0] bcnt;
    logic [12:0] fault_cnt;
    logic armed;
    logic [1:0] rot;
    sis_keys_t keys_prev;
    sis_disp_t disp;
    logic [6:0] min_soc;
    logic [3:0] mode;
    logic [10:0] win_start;
    logic [10:0] win_end;
    logic win_valid;
    logic [10:0] sys_time;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic fault_prev;
    logic ack;
    logic [31:0] rdata;
    logic op_blue;
    logic err_red;
    logic batl_green;
    logic charge_req;
    logic irq;
    sis_rgb_t status;
    sis_lamp_t [3:0] chg;
  } sis_state_t;

  sis_state_t state_reg;
  sis_state_t state_next;

  logic phase_on;
  logic [1:0] level;
  logic full;
  logic in_window;
  logic quiet_chg;
  sis_lamp_t [3:0] chg_calc;

  function automatic logic [31:0] sis_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic sis_gate(input sis_inv_t st, input logic [6:0] soc,
                                    input logic [6:0] new_min);
    return (st != INV_WAIT) || ({1'b0, soc} >= ({1'b0, new_min} + SOC_MARGIN));
  endfunction

  assign phase_on = state_reg.phase < ON_TICKS;
  assign full = soc_i >= SOC_FULL;
  assign level = (soc_i >= SOC_Q3) ? 2'h3 : (soc_i >= SOC_Q2) ? 2'h2 :
                 (soc_i >= SOC_Q1) ? 2'h1 : 2'h0;
  assign quiet_chg = bat_fault_i || bat_warning_i || (state_reg.bst != BAT_RUN);
  assign in_window = (state_reg.win_start <= state_reg.win_end) ?
                     (state_reg.sys_time >= state_reg.win_start &&
                      state_reg.sys_time < state_reg.win_end) :
                     (state_reg.sys_time >= state_reg.win_start ||
                      state_reg.sys_time < state_reg.win_end);

  for (genvar i = 0; i < 4; i++) begin : g_lamp
    logic below;
    logic at;
    assign below = 2'(i) < level;
    assign at = 2'(i) == level;
    always_comb begin
      chg_calc[i] = '0;
      if (state_reg.bst == BAT_SHUT || state_reg.bst == BAT_FADE) begin
        chg_calc[i].blue = state_reg.rot == 2'(i);
      end else if (!quiet_chg && bat_charging_i) begin
        chg_calc[i].green = full || below || (at && state_reg.slow_on);
      end else if (!quiet_chg && bat_discharging_i) begin
        chg_calc[i].green = (below || at) && state_reg.slow_on;
      end else if (!quiet_chg && bat_link_ok_i) begin
        chg_calc[i].green = below || at;
      end
    end
  end

  always_comb begin
    logic req;
    logic accept;
    logic [31:0] wv;
    logic [IRQ_W-1:0] set;
    logic [IRQ_W-1:0] clr;
    logic key_hit;
    logic propose;
    logic [6:0] prop_min;
    logic [3:0] prop_mode;
    sis_keys_t kr;
    req = 1'b0;
    accept = 1'b0;
    wv = '0;
    set = '0;
    clr = '0;
    key_hit = 1'b0;
    propose = 1'b0;
    prop_min = state_reg.min_soc;
    prop_mode = state_reg.mode;
    kr = '0;
    state_next = state_reg;

    state_next.tick = state_reg.tick_cnt == TICK_LAST;
    state_next.tick_cnt = state_next.tick ? '0 : state_reg.tick_cnt + 25'h0000001;
    if (state_reg.tick) begin
      state_next.phase = (state_reg.phase == CYCLE_TICKS - 6'h01) ? '0 :
                         state_reg.phase + 6'h01;
      state_next.fast_on = !state_reg.fast_on;
      if (state_reg.slow_cnt == SLOW_TICKS - 3'h1) begin
        state_next.slow_cnt = '0;
        state_next.slow_on = !state_reg.slow_on;
      end else begin
        state_next.slow_cnt = state_reg.slow_cnt + 3'h1;
      end
    end

    state_next.op_blue = (inv_state_i == INV_NORMAL) ||
                         (inv_state_i == INV_WAIT && state_reg.slow_on);
    state_next.err_red = inv_state_i == INV_FAULT;
    state_next.batl_green = (inv_bat_link_i == LINK_OK) ||
                            (inv_bat_link_i == LINK_IDLE && state_reg.slow_on);

    kr = keys_i & ~state_reg.keys_prev;
    state_next.keys_prev = keys_i;
    key_hit = |kr;
    if (inv_state_i == INV_FAULT) begin
      state_next.disp.page = PAGE_FAULT;
      state_next.disp.edit = 1'b0;
      state_next.disp.code = inv_err_code_i;
    end else begin
      state_next.disp.code = '0;
      if (state_reg.disp.page == PAGE_FAULT) begin
        state_next.disp.page = PAGE_POWER;
      end
      if (state_reg.disp.edit) begin
        if (kr.esc) begin
          state_next.disp.edit = 1'b0;
        end else if (kr.enter) begin
          state_next.disp.edit = 1'b0;
          propose = 1'b1;
          prop_min = state_reg.disp.value;
        end else if (kr.up && state_reg.disp.value < SOC_FULL) begin
          state_next.disp.value = state_reg.disp.value + 7'h01;
        end else if (kr.down && state_reg.disp.value != 7'h00) begin
          state_next.disp.value = state_reg.disp.value - 7'h01;
        end
      end else begin
        if (kr.esc) begin
          state_next.disp.page = PAGE_POWER;
        end else if (kr.up) begin
          state_next.disp.page = (state_reg.disp.page == PAGE_POWER) ? PAGE_BATTERY :
                                 sis_page_t'(state_reg.disp.page - 2'h1);
        end else if (kr.down) begin
          state_next.disp.page = (state_reg.disp.page == PAGE_BATTERY) ? PAGE_POWER :
                                 sis_page_t'(state_reg.disp.page + 2'h1);
        end else if (kr.enter && state_reg.disp.page == PAGE_BATTERY) begin
          state_next.disp.edit = 1'b1;
          state_next.disp.value = state_reg.min_soc;
        end
      end
    end

    // Avalon slave: one wait cycle, read data registered before the answer.
    req = avs_read_i || avs_write_i;
    accept = req && state_reg.ack;
    state_next.ack = req && !state_reg.ack;
    if (req && !state_reg.ack) begin
      case (avs_address_i)
        REG_STATUS: state_next.rdata = {24'h0, state_reg.charge_req, state_reg.disp.edit,
                                        state_reg.disp.page, 1'b0, state_reg.bst};
        REG_IRQ_STATUS: state_next.rdata = 32'(state_reg.irq_stat);
        REG_IRQ_MASK: state_next.rdata = 32'(state_reg.irq_mask);
        REG_SETTING: state_next.rdata = {20'h0, state_reg.mode, 1'b0, state_reg.min_soc};
        REG_CHG_WINDOW: state_next.rdata = {5'h0, state_reg.win_end, 5'h0,
                                            state_reg.win_start};
        REG_SYS_TIME: state_next.rdata = {21'h0, state_reg.sys_time};
        default: state_next.rdata = '0;
      endcase
    end
    if (accept && avs_read_i && avs_address_i == REG_IRQ_STATUS) begin
      // Only bits already returned are cleared, so later events survive.
      clr = state_reg.rdata[IRQ_W-1:0];
    end
    if (accept && avs_write_i) begin
      case (avs_address_i)
        REG_IRQ_MASK: begin
          wv = sis_merge(32'(state_reg.irq_mask), avs_writedata_i, avs_byteenable_i);
          state_next.irq_mask = wv[IRQ_W-1:0];
        end
        REG_SETTING: begin
          wv = sis_merge({20'h0, state_reg.mode, 1'b0, state_reg.min_soc},
                         avs_writedata_i, avs_byteenable_i);
          propose = 1'b1;
          prop_min = wv[6:0];
          prop_mode = wv[11:8];
        end
        REG_CHG_WINDOW: begin
          wv = sis_merge({5'h0, state_reg.win_end, 5'h0, state_reg.win_start},
                         avs_writedata_i, avs_byteenable_i);
          state_next.win_start = wv[10:0];
          state_next.win_end = wv[26:16];
          state_next.win_valid = 1'b1;
        end
        REG_SYS_TIME: begin
          wv = sis_merge({21'h0, state_reg.sys_time}, avs_writedata_i, avs_byteenable_i);
          state_next.sys_time = wv[10:0];
        end
        default: begin
        end
      endcase
    end

    if (propose) begin
      if (sis_gate(inv_state_i, soc_i, prop_min)) begin
        state_next.min_soc = prop_min;
        state_next.mode = prop_mode;
        set[IRQ_APPLIED] = 1'b1;
      end else begin
        set[IRQ_REJECTED] = 1'b1;
      end
    end
    state_next.charge_req = state_reg.win_valid && in_window && inv_state_i != INV_FAULT &&
                            bat_fault_i == 1'b0;

    state_next.fault_prev = bat_fault_i;
    set[IRQ_FAULT] = bat_fault_i && !state_reg.fault_prev;
    if (!bat_fault_i) begin
      state_next.fault_cnt = '0;
    end else if (state_reg.tick && state_reg.fault_cnt != FAULT_TICKS) begin
      state_next.fault_cnt = state_reg.fault_cnt + 13'h0001;
    end

    if (state_reg.tick && (state_reg.bst == BAT_SHUT || state_reg.bst == BAT_FADE)) begin
      state_next.rot = state_reg.rot + 2'h1;
    end
    case (state_reg.bst)
      BAT_OFF: begin
        if (!battery_power_button_i) begin
          state_next.bcnt = '0;
        end else if (state_reg.tick) begin
          if (state_reg.bcnt == ACT_TICKS - 13'h0001) begin
            state_next.bst = BAT_SELFTEST;
            state_next.bcnt = '0;
          end else begin
            state_next.bcnt = state_reg.bcnt + 13'h0001;
          end
        end
      end
      BAT_SELFTEST: begin
        if (state_reg.tick) begin
          if (state_reg.bcnt == SELFTEST_TICKS - 13'h0001) begin
            state_next.bst = BAT_LINKWAIT;
            state_next.bcnt = '0;
          end else begin
            state_next.bcnt = state_reg.bcnt + 13'h0001;
          end
        end
      end
      BAT_LINKWAIT: begin
        if (bat_link_ok_i) begin
          state_next.bst = BAT_RUN;
          state_next.armed = 1'b0;
          state_next.bcnt = '0;
          set[IRQ_STARTED] = 1'b1;
        end
      end
      BAT_RUN: begin
        if (!battery_power_button_i) begin
          state_next.armed = 1'b1;
          state_next.bcnt = '0;
        end else if (state_reg.armed && state_reg.tick) begin
          if (state_reg.bcnt == SHUT_TICKS) begin
            state_next.bst = BAT_SHUT;
            state_next.bcnt = '0;
          end else begin
            state_next.bcnt = state_reg.bcnt + 13'h0001;
          end
        end
      end
      BAT_SHUT: begin
        if (!battery_power_button_i) begin
          state_next.bst = BAT_FADE;
          state_next.bcnt = '0;
        end
      end
      BAT_FADE: begin
        if (state_reg.tick) begin
          if (state_reg.bcnt == FADE_TICKS - 13'h0001) begin
            state_next.bst = BAT_OFF;
            state_next.bcnt = '0;
            set[IRQ_STOPPED] = 1'b1;
          end else begin
            state_next.bcnt = state_reg.bcnt + 13'h0001;
          end
        end
      end
      default: begin
        state_next.bst = BAT_OFF;
        state_next.bcnt = '0;
      end
    endcase

    state_next.status = '0;
    if (state_reg.bst == BAT_OFF) begin
      state_next.status = '0;
    end else if (bat_fault_i) begin
      state_next.status.red = (state_reg.fault_cnt != FAULT_TICKS) || phase_on;
    end else if (bat_warning_i) begin
      state_next.status.red = phase_on;
      state_next.status.green = phase_on;
    end else if (state_reg.bst == BAT_SELFTEST) begin
      state_next.status.red = state_reg.fast_on;
      state_next.status.green = state_reg.fast_on;
    end else if (state_reg.bst == BAT_LINKWAIT) begin
      state_next.status.green = state_reg.slow_on;
    end else if (state_reg.bst != BAT_RUN) begin
      state_next.status.green = 1'b1;
    end else if (bat_charging_i || bat_discharging_i || bat_link_ok_i) begin
      state_next.status.green = 1'b1;
    end else begin
      state_next.status.green = phase_on;
    end
    state_next.chg = chg_calc;

    set[IRQ_KEY] = key_hit;
    // A new event wins over a clear in the same cycle.
    state_next.irq_stat = (state_reg.irq_stat & ~clr) | set;
    state_next.irq = |(state_next.irq_stat & state_reg.irq_mask);
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= '0;
      state_reg.min_soc <= MIN_SOC_RST;
      state_reg.mode <= MODE_RST;
      state_reg.bst <= BAT_OFF;
      state_reg.disp.page <= PAGE_POWER;
    end else begin
      state_reg <= state_next;
    end
  end

  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !state_reg.ack;
  assign avs_readdata_o = state_reg.rdata;
  assign irq_o = state_reg.irq;
  assign op_lamp_blue_o = state_reg.op_blue;
  assign err_lamp_red_o = state_reg.err_red;
  assign bat_lamp_green_o = state_reg.batl_green;
  assign disp_o = state_reg.disp;
  assign charge_req_o = state_reg.charge_req;
  assign status_lamp_o = state_reg.status;
  assign charge_level_lamp_first_o = state_reg.chg[0];
  assign charge_level_lamp_second_o = state_reg.chg[1];
  assign charge_level_lamp_third_o = state_reg.chg[2];
  assign charge_level_lamp_fourth_o = state_reg.chg[3];
endmodule

// ===== design/sis_pkg.sv
/*
  Shared constants and types of the status indicator sequencer: clock and
  timebase figures, lamp pattern durations, register map and carriers.
  Assumes a single 200 MHz system clock feeding every user of this package.
*/
package sis_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned TICK_MS = 100;
  localparam int unsigned TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned ACT_HOLD_MS = 1000;
  localparam int unsigned SELFTEST_MS = 3000;
  localparam int unsigned SHUT_HOLD_MS = 1000;
  localparam int unsigned FADE_MS = 2400;
  localparam int unsigned SLOW_BLINK_MS = 500;
  localparam int unsigned FLASH_ON_MS = 1000;
  localparam int unsigned FLASH_OFF_MS = 4000;
  localparam int unsigned FAULT_SOLID_MIN = 10;
  localparam logic [12:0] ACT_TICKS = 13'(ACT_HOLD_MS / TICK_MS);
  localparam logic [12:0] SELFTEST_TICKS = 13'(SELFTEST_MS / TICK_MS);
  localparam logic [12:0] SHUT_TICKS = 13'(SHUT_HOLD_MS / TICK_MS);
  localparam logic [12:0] FADE_TICKS = 13'(FADE_MS / TICK_MS);
  localparam logic [2:0] SLOW_TICKS = 3'(SLOW_BLINK_MS / TICK_MS);
  localparam logic [5:0] ON_TICKS = 6'(FLASH_ON_MS / TICK_MS);
  localparam logic [5:0] CYCLE_TICKS = 6'((FLASH_ON_MS + FLASH_OFF_MS) / TICK_MS);
  localparam logic [12:0] FAULT_TICKS = 13'(FAULT_SOLID_MIN * 60 * 1000 / TICK_MS);
  localparam logic [7:0] SOC_MARGIN = 8'h02;
  localparam logic [6:0] SOC_Q1 = 7'h19;
  localparam logic [6:0] SOC_Q2 = 7'h32;
  localparam logic [6:0] SOC_Q3 = 7'h4b;
  localparam logic [6:0] SOC_FULL = 7'h64;
  localparam logic [5:0] REG_STATUS = 6'h00;
  localparam logic [5:0] REG_IRQ_STATUS = 6'h04;
  localparam logic [5:0] REG_IRQ_MASK = 6'h08;
  localparam logic [5:0] REG_SETTING = 6'h0c;
  localparam logic [5:0] REG_CHG_WINDOW = 6'h10;
  localparam logic [5:0] REG_SYS_TIME = 6'h14;
  localparam int unsigned IRQ_W = 6;
  localparam int unsigned IRQ_KEY = 0;
  localparam int unsigned IRQ_APPLIED = 1;
  localparam int unsigned IRQ_REJECTED = 2;
  localparam int unsigned IRQ_FAULT = 3;
  localparam int unsigned IRQ_STARTED = 4;
  localparam int unsigned IRQ_STOPPED = 5;
  localparam logic [6:0] MIN_SOC_RST = 7'h0a;
  localparam logic [3:0] MODE_RST = 4'h0;

  typedef enum logic [1:0] {
    INV_WAIT = 2'h0,
    INV_NORMAL = 2'h1,
    INV_FAULT = 2'h2
  } sis_inv_t;

  typedef enum logic [1:0] {
    LINK_IDLE = 2'h0,
    LINK_OK = 2'h1,
    LINK_FAULT = 2'h2
  } sis_link_t;

  typedef enum logic [1:0] {
    PAGE_POWER = 2'h0,
    PAGE_DAILY = 2'h1,
    PAGE_BATTERY = 2'h2,
    PAGE_FAULT = 2'h3
  } sis_page_t;

  typedef enum logic [2:0] {
    BAT_OFF = 3'h0,
    BAT_SELFTEST = 3'h1,
    BAT_LINKWAIT = 3'h2,
    BAT_RUN = 3'h3,
    BAT_SHUT = 3'h4,
    BAT_FADE = 3'h5
  } sis_bat_t;

  typedef struct packed {
    logic red;
    logic green;
    logic blue;
  } sis_rgb_t;

  typedef struct packed {
    logic green;
    logic blue;
  } sis_lamp_t;

  typedef struct packed {
    logic esc;
    logic up;
    logic down;
    logic enter;
  } sis_keys_t;

  typedef struct packed {
    sis_page_t page;
    logic edit;
    logic [6:0] value;
    logic [15:0] code;
  } sis_disp_t;
endpackage

// ===== tb/sis_chk.sv
/* Port checker for sis_top, bound to every instance.
   Assumes one clock domain and the low-active asynchronous reset. */
module sis_chk (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire sis_pkg::sis_inv_t inv_state_i,
  input wire sis_pkg::sis_link_t inv_bat_link_i,
  input wire logic [15:0] inv_err_code_i,
  input wire logic op_lamp_blue_o,
  input wire logic err_lamp_red_o,
  input wire logic bat_lamp_green_o,
  input wire sis_pkg::sis_disp_t disp_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import sis_pkg::*;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_op_normal: assert property (inv_state_i == INV_NORMAL |=> op_lamp_blue_o)
    else $error("operating lamp dark in normal state");
  a_op_fault: assert property (inv_state_i == INV_FAULT |=> !op_lamp_blue_o)
    else $error("operating lamp lit on fault");
  a_err_fault: assert property (inv_state_i == INV_FAULT |=> err_lamp_red_o)
    else $error("error lamp dark on fault");
  a_err_normal: assert property (inv_state_i == INV_NORMAL |=> !err_lamp_red_o)
    else $error("error lamp lit in normal state");
  a_bat_ok: assert property (inv_bat_link_i == LINK_OK |=> bat_lamp_green_o)
    else $error("battery lamp dark on healthy link");
  a_bat_fault: assert property (inv_bat_link_i == LINK_FAULT |=> !bat_lamp_green_o)
    else $error("battery lamp lit on faulted link");
  a_fault_disp: assert property (inv_state_i == INV_FAULT |=>
    disp_o.page == PAGE_FAULT && disp_o.code == $past(inv_err_code_i))
    else $error("fault page or code wrong");
  a_wait_once: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o)
    else $error("bus answer late");
  c_fault: cover property (err_lamp_red_o);
  c_bus: cover property (avs_read_i && !avs_waitrequest_o);
  c_page: cover property (disp_o.page == PAGE_BATTERY && disp_o.edit);
endmodule

bind sis_top sis_chk u_chk (.*);

// ===== tb/sis_user.sv
/* Operator model: presses the battery power button and the panel keys.
   Assumes its tasks are called from one process right after a clock edge. */
module sis_user (
  input wire logic clk_i,
  output logic btn_o,
  output sis_pkg::sis_keys_t keys_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import sis_pkg::*;
  initial begin
    btn_o = 1'b0;
    keys_o = '0;
  end
  task automatic hold(input int cyc);
    @(posedge clk_i);
    btn_o <= 1'b1;
    repeat (cyc) @(posedge clk_i);
    btn_o <= 1'b0;
  endtask
  // Two edges high gives the shortest press that still leaves a clean low gap.
  task automatic key(input sis_keys_t k);
    @(posedge clk_i);
    keys_o <= k;
    repeat (2) @(posedge clk_i);
    keys_o <= '0;
  endtask
endmodule

// ===== tb/testbench.sv
/* Self-checking bench for sis_top with a four-cycle timebase tick.
   Assumes sis_user stands for the operator and sis_chk is bound. */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import sis_pkg::*;
  localparam int unsigned TK = 4;
  int err_total = 0;
  int comparisons = 0;
  int cnt;
  logic sys_clk_i, rst_n_i, avs_read_i, avs_write_i, avs_waitrequest_o, irq_o;
  logic battery_power_button_i, bat_link_ok_i, bat_charging_i, bat_discharging_i;
  logic bat_fault_i, bat_warning_i, op_lamp_blue_o, err_lamp_red_o, bat_lamp_green_o;
  logic charge_req_o;
  logic [5:0] avs_address_i;
  logic [3:0] avs_byteenable_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  logic [15:0] inv_err_code_i;
  logic [6:0] soc_i;
  logic [7:0] v, ov, av;
  sis_inv_t inv_state_i;
  sis_link_t inv_bat_link_i;
  sis_keys_t keys_i;
  sis_disp_t disp_o;
  sis_rgb_t status_lamp_o;
  sis_lamp_t charge_level_lamp_first_o, charge_level_lamp_second_o;
  sis_lamp_t charge_level_lamp_third_o, charge_level_lamp_fourth_o;
  assign v = {op_lamp_blue_o, err_lamp_red_o, bat_lamp_green_o, status_lamp_o.red,
    status_lamp_o.green, charge_level_lamp_first_o, charge_level_lamp_fourth_o.green};
  sis_user user (.clk_i(sys_clk_i), .btn_o(battery_power_button_i), .keys_o(keys_i));
  sis_top #(.TICK_CYCLES(TK)) DUT (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  // Two settling edges first, so the lamps' one-cycle lag never enters a window.
  task automatic win(input int n);
    repeat (2) @(posedge sys_clk_i);
    {ov, av, cnt} = {8'h00, 8'hff, 32'h0};
    repeat (n * TK) begin
      @(posedge sys_clk_i);
      ov |= v;
      av &= v;
      cnt += int'(v[3]);
    end
  endtask
  task automatic t_inverter;
    logic [5:0] e [3] = '{6'h22, 6'h33, 6'h0c};
    inv_err_code_i <= 16'h0e2a;
    for (int i = 0; i < 3; i++) begin
      inv_state_i <= sis_inv_t'(i);
      inv_bat_link_i <= sis_link_t'(i);
      win(12);
      chk({ov[7], av[7], ov[6], av[6], ov[5], av[5]}, e[i]);
    end
    chk({disp_o.page, disp_o.code}, {PAGE_FAULT, 16'h0e2a});
  endtask
  // Enter in edit mode confirms 0x0b as the new minimum while the inverter runs normally.
  task automatic t_keys;
    logic [3:0] k [11] = '{4'h2, 4'h2, 4'h2, 4'h4, 4'h1, 4'h4, 4'h8, 4'h1, 4'h4, 4'h1, 4'h8};
    logic [2:0] e [11] = '{3'h2, 3'h4, 3'h0, 3'h4, 3'h5, 3'h5, 3'h4, 3'h5, 3'h5, 3'h4, 3'h0};
    inv_state_i <= INV_NORMAL;
    win(1);
    for (int i = 0; i < 11; i++) begin
      user.key(sis_keys_t'(k[i]));
      @(posedge sys_clk_i);
      chk({disp_o.page, disp_o.edit}, e[i]);
      if (i == 5) chk(disp_o.value, 7'h0b);
    end
  endtask
  task automatic t_regs;
    bus(1'b0, 6'h3c, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, REG_IRQ_MASK, 32'h3f);
    bus(1'b0, REG_IRQ_STATUS, 32'h0);
    chk({irq_o, q[0]}, 2'h3);
    bus(1'b0, REG_IRQ_STATUS, 32'h0);
    win(1);
    chk(q, 32'h0);
    chk(irq_o, 1'b0);
    inv_state_i <= INV_WAIT;
    soc_i <= 7'h14;
    bus(1'b1, REG_SETTING, 32'h13);
    bus(1'b0, REG_SETTING, 32'h0);
    chk(q[6:0], 7'h0b);
    bus(1'b1, REG_SETTING, 32'h12);
    bus(1'b0, REG_SETTING, 32'h0);
    chk(q[6:0], 7'h12);
    bus(1'b0, REG_IRQ_STATUS, 32'h0);
    chk(q[2:1], 2'h3);
  endtask
  task automatic t_window;
    inv_state_i <= INV_NORMAL;
    bus(1'b1, REG_SYS_TIME, 32'h64);
    bus(1'b1, REG_CHG_WINDOW, 32'h00c8_0032);
    win(1);
    chk(charge_req_o, 1'b1);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(q, 32'h80);
    bus(1'b1, REG_SYS_TIME, 32'h12c);
    win(1);
    chk(charge_req_o, 1'b0);
  endtask
  task automatic t_battery;
    soc_i <= 7'h3c;
    user.hold(12 * TK);
    win(4);
    chk({ov[4], av[4], ov[3], av[3], ov[2]}, 5'h14);
    win(25);
    win(12);
    chk({ov[4], ov[3], av[3], ov[2]}, 4'h4);
    bat_link_ok_i <= 1'b1;
    win(12);
    chk({ov[4], av[3], av[2], ov[1]}, 4'h6);
    chk({charge_level_lamp_second_o, charge_level_lamp_third_o, status_lamp_o.blue}, 5'h14);
    bat_charging_i <= 1'b1;
    win(12);
    chk({av[3], av[2], ov[1]}, 3'h6);
    {bat_charging_i, bat_discharging_i, soc_i} <= {2'h1, 7'h50};
    win(12);
    chk({av[3], ov[2], av[2], ov[0], av[0]}, 5'h1a);
    soc_i <= 7'h0a;
    win(12);
    chk({ov[2], av[2], ov[0]}, 3'h4);
    {bat_discharging_i, bat_link_ok_i} <= 2'h0;
    win(50);
    chk({ov[4], ov[2], cnt[7:0]}, 10'h028);
    bat_warning_i <= 1'b1;
    win(50);
    chk({ov[4], av[4], cnt[7:0]}, 10'h228);
    bat_fault_i <= 1'b1;
    win(20);
    chk({av[4], ov[3]}, 2'h2);
    win(6000);
    win(50);
    chk({ov[4], av[4], ov[3]}, 3'h4);
    {bat_fault_i, bat_warning_i} <= 2'h0;
    user.hold(14 * TK);
    win(8);
    chk({ov[4], av[3], ov[1], av[1]}, 4'h6);
    win(16);
    win(4);
    chk(ov[4:0], 5'h00);
  endtask
  task automatic print_verdict;
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    repeat (60000) @(posedge sys_clk_i);
    err_total++;
    print_verdict();
  end
  initial begin
    {rst_n_i, avs_read_i, avs_write_i, bat_link_ok_i, bat_charging_i} = 5'h00;
    {bat_discharging_i, bat_fault_i, bat_warning_i, soc_i} = 10'h000;
    {avs_address_i, avs_writedata_i, inv_err_code_i} = 54'h0;
    avs_byteenable_i = 4'hf;
    inv_state_i = INV_WAIT;
    inv_bat_link_i = LINK_IDLE;
    repeat (8) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    t_inverter();
    t_keys();
    t_regs();
    t_window();
    t_battery();
    print_verdict();
  end
endmodule
